// ---- include/dca_params.svh ----
// Constants for the command and address decoder
`ifndef DCA_PARAMS_SVH
`define DCA_PARAMS_SVH
`define DCA_BANKS 8
`define DCA_BA_W 3
`define DCA_ADDR_W 14
`define DCA_COL_W 10
`define DCA_AP_BIT 10
`define DCA_BC_BIT 12
`define DCA_ROW_RST 14'h0000
`endif

// ---- include/dca_pkg.sv ----
// Types for the command and address decoder
package dca_pkg;
    typedef enum logic [2:0] {
        DCA_CMD_NOP = 3'b000,
        DCA_CMD_ACT = 3'b001,
        DCA_CMD_PRE = 3'b010,
        DCA_CMD_RD = 3'b011,
        DCA_CMD_WR = 3'b100,
        DCA_CMD_MRS = 3'b101,
        DCA_CMD_OTHER = 3'b110,
        DCA_CMD_DESEL = 3'b111
    } dca_cmd_e;
endpackage : dca_pkg

// ---- rtl/dca_cmd_decode.sv ----
// Combinational command truth table
`timescale 1ns/1ps
`default_nettype none
module dca_cmd_decode (
    // Strobes
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    // Decoded command
    output var dca_pkg::dca_cmd_e cmd_out
);
    wire [3:0] code = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    assign cmd_out =
        code[3] ? dca_pkg::DCA_CMD_DESEL :
        (code == 4'h3) ? dca_pkg::DCA_CMD_ACT :
        (code == 4'h2) ? dca_pkg::DCA_CMD_PRE :
        (code == 4'h5) ? dca_pkg::DCA_CMD_RD :
        (code == 4'h4) ? dca_pkg::DCA_CMD_WR :
        (code == 4'h0) ? dca_pkg::DCA_CMD_MRS :
        (code == 4'h7) ? dca_pkg::DCA_CMD_NOP :
        dca_pkg::DCA_CMD_OTHER;
endmodule : dca_cmd_decode
`default_nettype wire

// ---- rtl/dca_decoder.sv ----
// Command and address decode front end with per-bank open-row tracking
`timescale 1ns/1ps
`default_nettype none
`include "dca_params.svh"
module dca_decoder #(
    parameter int BANKS = `DCA_BANKS,
    parameter int BA_W = `DCA_BA_W,
    parameter int ADDR_W = `DCA_ADDR_W,
    parameter int COL_W = `DCA_COL_W
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // Command and address pins
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [BA_W-1:0] bank_in,
    input wire logic [ADDR_W-1:0] addr_in,
    // Decoded command as one-cycle strobes, then bank and held row, column and opcode fields
    output logic act_out,
    output logic pre_out,
    output logic pre_all_out,
    output logic rd_out,
    output logic wr_out,
    output logic mrs_out,
    output logic [BA_W-1:0] bank_out,
    output logic [ADDR_W-1:0] row_out,
    output logic [COL_W-1:0] col_out,
    output logic auto_pre_out,
    output logic burst_chop_out,
    output logic [ADDR_W-1:0] opcode_out,
    // Bank state
    output logic [BANKS-1:0] bank_open_out
);
    // Pins cross from the controller's domain; two stages before any decode
    logic [3:0] strb_s1_r, strb_s2_r;
    logic [BA_W-1:0] ba_s1_r, ba_s2_r;
    logic [ADDR_W-1:0] a_s1_r, a_s2_r;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strb_s1_r <= 4'hF;
            strb_s2_r <= 4'hF;
            ba_s1_r <= '0;
            ba_s2_r <= '0;
            a_s1_r <= '0;
            a_s2_r <= '0;
        end else if (clk_en_in) begin
            strb_s1_r <= {cs_n_in, ras_n_in, cas_n_in, we_n_in};
            strb_s2_r <= strb_s1_r;
            ba_s1_r <= bank_in;
            ba_s2_r <= ba_s1_r;
            a_s1_r <= addr_in;
            a_s2_r <= a_s1_r;
        end
    end

    dca_pkg::dca_cmd_e cmd;
    dca_cmd_decode u_dec (
        .cs_n_in(strb_s2_r[3]),
        .ras_n_in(strb_s2_r[2]),
        .cas_n_in(strb_s2_r[1]),
        .we_n_in(strb_s2_r[0]),
        .cmd_out(cmd)
    );

    wire is_act = (cmd == dca_pkg::DCA_CMD_ACT);
    wire is_pre = (cmd == dca_pkg::DCA_CMD_PRE);
    wire is_rd = (cmd == dca_pkg::DCA_CMD_RD);
    wire is_wr = (cmd == dca_pkg::DCA_CMD_WR);
    wire is_mrs = (cmd == dca_pkg::DCA_CMD_MRS);
    wire is_col = is_rd | is_wr;
    wire ap_bit = a_s2_r[`DCA_AP_BIT];
    wire pre_all = is_pre & ap_bit;
    wire auto_pre = is_col & ap_bit;
    wire chop = is_col & ~a_s2_r[`DCA_BC_BIT];

    // Bank open map; a NOP or deselect leaves it untouched
    logic [BANKS-1:0] open_r;
    genvar g;
    generate
        for (g = 0; g < BANKS; g++) begin : g_bank
            wire hit = (ba_s2_r == BA_W'(g));
            wire set_open = is_act & hit;
            // Auto-precharge closes the bank at the access; burst length is not modelled
            wire close = (is_pre & (ap_bit | hit)) | (auto_pre & hit);
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    open_r[g] <= 1'b0;
                end else if (clk_en_in) begin
                    if (set_open) begin
                        open_r[g] <= 1'b1;
                    end else if (close) begin
                        open_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // One short register per output; strobes last exactly one enabled cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            act_out <= 1'b0;
        end else if (clk_en_in) begin
            act_out <= is_act;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre_out <= 1'b0;
        end else if (clk_en_in) begin
            pre_out <= is_pre;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre_all_out <= 1'b0;
        end else if (clk_en_in) begin
            pre_all_out <= pre_all;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_out <= 1'b0;
        end else if (clk_en_in) begin
            rd_out <= is_rd;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_out <= 1'b0;
        end else if (clk_en_in) begin
            wr_out <= is_wr;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mrs_out <= 1'b0;
        end else if (clk_en_in) begin
            mrs_out <= is_mrs;
        end
    end

    // Bank follows every enabled cycle; qualify it with a strobe before use
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bank_out <= '0;
        end else if (clk_en_in) begin
            bank_out <= ba_s2_r;
        end
    end

    // Row, column and opcode keep their last value so a consumer may read them late; auto-precharge and chop are strobes
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            row_out <= `DCA_ROW_RST;
        end else if (clk_en_in && is_act) begin
            row_out <= a_s2_r;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            col_out <= '0;
        end else if (clk_en_in && is_col) begin
            col_out <= a_s2_r[COL_W-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            auto_pre_out <= 1'b0;
        end else if (clk_en_in) begin
            auto_pre_out <= auto_pre;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            burst_chop_out <= 1'b0;
        end else if (clk_en_in) begin
            burst_chop_out <= chop;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            opcode_out <= '0;
        end else if (clk_en_in && is_mrs) begin
            opcode_out <= a_s2_r;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bank_open_out <= '0;
        end else if (clk_en_in) begin
            bank_open_out <= open_r;
        end
    end
endmodule : dca_decoder
`default_nettype wire

// ---- sim/dca_ctrl_model.sv ----
// Controller model driving the command and address pins
`timescale 1ns/1ps
`default_nettype none
module dca_ctrl_model (
    input wire logic clk_in,
    output logic cs_n_out, ras_n_out, cas_n_out, we_n_out,
    output logic [2:0] bank_out,
    output logic [13:0] addr_out
);
    initial {cs_n_out, ras_n_out, cas_n_out, we_n_out, bank_out, addr_out} = 21'h1E0000;
    // Called just after an edge; pins hold across the next sampling edge
    task send(input logic [3:0] cmd, input logic [2:0] b, input logic [13:0] a);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = cmd;
        bank_out = b;
        addr_out = a;
        @(posedge clk_in);
        #1;
    endtask : send
    // Inverted stale values so a late sample cannot pass by luck
    task idle();
        cs_n_out = 1'b1;
        bank_out = ~bank_out;
        addr_out = ~addr_out;
    endtask : idle
endmodule : dca_ctrl_model
`default_nettype wire

// ---- sim/dca_decoder_props.sv ----
// Port timing checks for the decoder
`timescale 1ns/1ps
`default_nettype none
module dca_decoder_props (
    input wire logic clk_in, reset_n_in, clk_en_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
    input wire logic [13:0] addr_in, row_out,
    input wire logic [9:0] col_out,
    input wire logic act_out, pre_out, pre_all_out, rd_out, wr_out, auto_pre_out, burst_chop_out,
    input wire logic [7:0] bank_open_out
);
    // Enable history; the look-back checks only hold over fully enabled cycles
    logic [3:0] en_q = 4'h0;
    always @(posedge clk_in) en_q <= {en_q[2:0], clk_en_in};
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in || !clk_en_in || en_q != 4'hF);
    wire logic [3:0] c = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    wire logic x = rd_out | wr_out;
    AST_ACT: assert property (act_out == $past(c == 4'h3, 3)) else $error("act");
    AST_PRE: assert property (pre_out == $past(c == 4'h2, 3)) else $error("pre");
    AST_RW: assert property ({rd_out, wr_out} == {$past(c == 4'h5, 3), $past(c == 4'h4, 3)})
        else $error("rd wr");
    AST_CS: assert property ($past(cs_n_in, 3) |-> !(act_out | pre_out | x)) else $error("cs");
    AST_ROW: assert property (act_out |-> row_out == $past(addr_in, 3)) else $error("row");
    AST_COL: assert property (x |-> col_out == $past(addr_in[9:0], 3)) else $error("col");
    AST_AP: assert property (x |-> auto_pre_out == $past(addr_in[10], 3)) else $error("ap");
    AST_BC: assert property (x |-> burst_chop_out != $past(addr_in[12], 3)) else $error("bc");
    AST_ALL: assert property (pre_out && pre_all_out |=> bank_open_out == 8'h00)
        else $error("all");
    AST_NOP: assert property ($past(c == 4'h7, 4) |-> $stable(bank_open_out))
        else $error("nop");
    cover property (act_out);
    cover property (x && auto_pre_out);
    cover property (pre_out && pre_all_out);
endmodule : dca_decoder_props
`default_nettype wire

// ---- sim/dca_decoder_tb_top.sv ----
// Self-checking bench for the command and address decoder
`timescale 1ns/1ps
`default_nettype none
module dca_decoder_tb_top;
    localparam logic [3:0] C_ACT = 4'h3, C_PRE = 4'h2, C_RD = 4'h5, C_WR = 4'h4, C_NOP = 4'h7;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic clk_en = 1'b1;
    wire logic cs_n, ras_n, cas_n, we_n, act, pre, pall, rd, wr, mrs, ap, bc;
    wire logic [2:0] ba, bnk;
    wire logic [13:0] a, row, opc;
    wire logic [9:0] col;
    wire logic [7:0] bopen;
    int errors = 0;
    int n_checks = 0;
    always #50 clk_in = ~clk_in;
    dca_ctrl_model m (.clk_in(clk_in), .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n),
        .we_n_out(we_n), .bank_out(ba), .addr_out(a));
    dca_decoder dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en), .cs_n_in(cs_n),
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .bank_in(ba), .addr_in(a),
        .act_out(act), .pre_out(pre), .pre_all_out(pall), .rd_out(rd), .wr_out(wr), .mrs_out(mrs),
        .bank_out(bnk), .row_out(row), .col_out(col), .auto_pre_out(ap), .burst_chop_out(bc),
        .opcode_out(opc), .bank_open_out(bopen));
    task chk(input string nm, input logic [13:0] got, input logic [13:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wt
    task summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task t_act_rd();
        m.send(C_ACT, 3'h5, 14'h2A5C);
        m.send(C_RD, 3'h5, 14'h07FF);
        m.idle();
        wt(2);
        chk("rd", rd, 14'h0001);
        chk("auto_pre", ap, 14'h0001);
        chk("chop", bc, 14'h0001);
        chk("col", col, 14'h03FF);
        chk("row", row, 14'h2A5C);
        chk("open", bopen, 14'h0020);
        wt(1);
        chk("closed", bopen, 14'h0000);
    endtask : t_act_rd
    task t_cs();
        m.send(C_ACT, 3'h1, 14'h0111);
        m.send(4'hB, 3'h2, 14'h3333);
        m.send(C_NOP, 3'h1, 14'h0222);
        m.idle();
        wt(5);
        chk("desel open", bopen, 14'h0002);
        chk("desel row", row, 14'h0111);
    endtask : t_cs
    task t_pre();
        m.send(C_ACT, 3'h0, 14'h0001);
        m.send(C_ACT, 3'h6, 14'h0002);
        m.send(C_PRE, 3'h1, 14'h3BFF);
        m.idle();
        wt(5);
        chk("pre one", bopen, 14'h0041);
        m.send(C_PRE, 3'h6, 14'h0400);
        m.idle();
        wt(2);
        chk("pre", pre, 14'h0001);
        chk("pre all", pall, 14'h0001);
        wt(1);
        chk("all shut", bopen, 14'h0000);
    endtask : t_pre
    task t_wr_mrs();
        m.send(C_WR, 3'h7, 14'h1155);
        m.idle();
        wt(2);
        chk("wr", wr, 14'h0001);
        chk("wr chop", bc, 14'h0000);
        chk("wr ap", ap, 14'h0000);
        chk("wr col", col, 14'h0155);
        chk("wr bank", bnk, 14'h0007);
        m.send(4'h0, 3'h0, 14'h1234);
        m.idle();
        wt(2);
        chk("mrs", mrs, 14'h0001);
        chk("opcode", opc, 14'h1234);
    endtask : t_wr_mrs
    task t_freeze();
        clk_en = 1'b0;
        m.send(C_ACT, 3'h3, 14'h0ABC);
        m.idle();
        wt(4);
        chk("frozen act", act, 14'h0000);
        clk_en = 1'b1;
        wt(4);
        chk("untaken", bopen, 14'h0000);
        m.send(C_ACT, 3'h3, 14'h0ABC);
        m.idle();
        clk_en = 1'b0;
        wt(3);
        chk("held act", act, 14'h0000);
        clk_en = 1'b1;
        wt(2);
        chk("resumed act", act, 14'h0001);
        wt(1);
        chk("resumed open", bopen, 14'h0008);
        reset_n_in = 1'b0;
        wt(1);
        chk("reset open", bopen, 14'h0000);
        chk("reset row", row, 14'h0000);
        reset_n_in = 1'b1;
        wt(4);
        m.send(C_ACT, 3'h2, 14'h0123);
        m.idle();
        wt(2);
        chk("post act", act, 14'h0001);
        chk("post row", row, 14'h0123);
        chk("post bank", bnk, 14'h0002);
    endtask : t_freeze
    initial begin
        wt(6);
        reset_n_in = 1'b1;
        t_act_rd();
        t_cs();
        t_pre();
        t_wr_mrs();
        t_freeze();
        summarize();
    end
    initial begin
        repeat (500) @(posedge clk_in);
        errors++;
        summarize();
    end
endmodule : dca_decoder_tb_top
bind dca_decoder dca_decoder_props p (.*);
`default_nettype wire
